//--- logic/eal_pkg.sv
// constants and types shared by the arithmetic and logic unit
package eal_pkg;

  // ****************************************
  // status flag positions
  // ****************************************
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ****************************************
  // operands and timing
  // ****************************************
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int unsigned BYTE_OP_CYCLES = 1;
  localparam int unsigned WORD_OP_CYCLES = 2;

  // ****************************************
  // operation codes from the decoder
  // ****************************************
  typedef enum logic [4:0] {
    op_nop,
    op_add,
    op_add_carry,
    op_word_pair_add_imm,
    op_sub,
    op_minus_immediate,
    op_sub_borrow,
    op_minus_imm_with_borrow,
    op_word_pair_minus_imm,
    op_and,
    op_mask_with_imm,
    op_or,
    op_merge_imm_bits,
    op_toggle_xor,
    op_raise_bits,
    op_drop_bits,
    op_self_mask_test
  } eal_op_t;

endpackage : eal_pkg

//--- logic/eal_core_if.sv
// signals between the control unit and the byte adder
`timescale 1ns/1ps
interface eal_core_if;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic sub;
  logic [7:0] res;
  logic cout;
  logic half;
  logic ovf;

  modport ctrl (output a, output b, output cin, output sub, input res, input cout, input half, input ovf);
  modport core (input a, input b, input cin, input sub, output res, output cout, output half, output ovf);
endinterface : eal_core_if

//--- logic/eal_byte_core.sv
// eight-bit adder and subtractor with carry, half-carry and overflow
`timescale 1ns/1ps
module eal_byte_core (
  eal_core_if.core cif
);

  logic [8:0] full;
  logic [4:0] nib;

  always_comb
  begin
    // on subtract, cout and half mean borrow out of bit 7 and bit 3
    if (cif.sub)
    begin
      full = {1'b0, cif.a} - {1'b0, cif.b} - {8'h00, cif.cin};
      nib = {1'b0, cif.a[3:0]} - {1'b0, cif.b[3:0]} - {4'h0, cif.cin};
      cif.ovf = (cif.a[7] & ~cif.b[7] & ~full[7]) | (~cif.a[7] & cif.b[7] & full[7]);
    end
    else
    begin
      full = {1'b0, cif.a} + {1'b0, cif.b} + {8'h00, cif.cin};
      nib = {1'b0, cif.a[3:0]} + {1'b0, cif.b[3:0]} + {4'h0, cif.cin};
      cif.ovf = (cif.a[7] & cif.b[7] & ~full[7]) | (~cif.a[7] & ~cif.b[7] & full[7]);
    end
    cif.res = full[7:0];
    cif.cout = full[8];
    cif.half = nib[4];
  end

endmodule : eal_byte_core

//--- logic/eal_alu_top.sv
// eight-bit arithmetic and logic unit with status flags
`timescale 1ns/1ps

// What this block does
// - add and add-with-carry write dest plus source, set Z C N V H, one cycle
// - word-pair add of immediate writes the pair, sets Z C N V S, two cycles
// - subtract and subtract-with-borrow write dest minus source, set Z C N V H
// - subtract immediate writes dest minus immediate, sets Z C N V H, one cycle
// - subtract immediate with borrow also subtracts carry, sets Z C N V H
// - word-pair subtract of immediate writes the pair, sets Z C N V S, two cycles
// - AND with register or immediate writes result, sets only Z N V, one cycle
// - OR, OR immediate and XOR write result, set Z N V, one cycle
// - bit raise ORs immediate into dest, sets Z N V, one cycle
// - bit drop ANDs dest with 0xFF minus immediate, sets Z N V, one cycle
// - self test ANDs dest with itself, value unchanged, sets Z N V
module eal_alu_top #(
  parameter int unsigned IDX_W = 5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire eal_pkg::eal_op_t op_code,
  input wire logic [IDX_W-1:0] dest_idx,
  input wire logic [7:0] dest_val,
  input wire logic [7:0] source_reg,
  input wire logic [7:0] imm_value,
  input wire logic [7:0] pair_high_val,
  output logic busy,
  output logic done,
  output logic wr_byte,
  output logic wr_pair,
  output logic [IDX_W-1:0] wr_idx,
  output logic [IDX_W-1:0] wr_idx_high,
  output logic [7:0] result_low,
  output logic [7:0] result_high,
  output logic [7:0] status_flags
);

  // ****************************************
  // operation decoding
  // ****************************************
  function automatic logic op_is_sub(input eal_pkg::eal_op_t op);
    op_is_sub = (op == eal_pkg::op_sub) || (op == eal_pkg::op_minus_immediate) ||
                (op == eal_pkg::op_sub_borrow) || (op == eal_pkg::op_minus_imm_with_borrow) ||
                (op == eal_pkg::op_word_pair_minus_imm);
  endfunction : op_is_sub

  function automatic logic op_takes_carry(input eal_pkg::eal_op_t op);
    op_takes_carry = (op == eal_pkg::op_add_carry) || (op == eal_pkg::op_sub_borrow) ||
                     (op == eal_pkg::op_minus_imm_with_borrow);
  endfunction : op_takes_carry

  function automatic logic op_uses_imm(input eal_pkg::eal_op_t op);
    op_uses_imm = (op == eal_pkg::op_minus_immediate) || (op == eal_pkg::op_minus_imm_with_borrow) ||
                  (op == eal_pkg::op_word_pair_add_imm) || (op == eal_pkg::op_word_pair_minus_imm) ||
                  (op == eal_pkg::op_mask_with_imm) || (op == eal_pkg::op_merge_imm_bits) ||
                  (op == eal_pkg::op_raise_bits) || (op == eal_pkg::op_drop_bits);
  endfunction : op_uses_imm

  function automatic logic op_is_word(input eal_pkg::eal_op_t op);
    op_is_word = (op == eal_pkg::op_word_pair_add_imm) || (op == eal_pkg::op_word_pair_minus_imm);
  endfunction : op_is_word

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [0:0] {
    st_idle,
    st_word_high
  } eal_state_t;

  eal_state_t state_q, state_d;
  logic [7:0] flags_q, flags_d;
  logic [7:0] res_lo_q, res_lo_d;
  logic [7:0] res_hi_q, res_hi_d;
  logic [7:0] hi_src_q, hi_src_d;
  logic lo_carry_q, lo_carry_d;
  logic lo_zero_q, lo_zero_d;
  logic word_sub_q, word_sub_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic [IDX_W-1:0] idx_hi_q, idx_hi_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic wr_byte_q, wr_byte_d;
  logic wr_pair_q, wr_pair_d;
  logic [7:0] operand;
  logic [7:0] logic_res;

  eal_core_if cif ();

  eal_byte_core u_core (
    .cif(cif.core)
  );

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    flags_d = flags_q;
    res_lo_d = res_lo_q;
    res_hi_d = res_hi_q;
    hi_src_d = hi_src_q;
    lo_carry_d = lo_carry_q;
    lo_zero_d = lo_zero_q;
    word_sub_d = word_sub_q;
    idx_d = idx_q;
    idx_hi_d = idx_hi_q;
    busy_d = busy_q;
    done_d = 1'b0;
    wr_byte_d = 1'b0;
    wr_pair_d = 1'b0;
    operand = op_uses_imm(op_code) ? imm_value : source_reg;
    logic_res = eal_pkg::BYTE_ZERO;
    cif.a = dest_val;
    cif.b = operand;
    cif.cin = op_takes_carry(op_code) ? flags_q[eal_pkg::FLAG_C] : 1'b0;
    cif.sub = op_is_sub(op_code);

    unique case (state_q)
      st_idle:
      begin
        if (op_valid && op_code != eal_pkg::op_nop)
        begin
          idx_d = dest_idx;
          idx_hi_d = dest_idx + {{(IDX_W-1){1'b0}}, 1'b1};
          if (op_is_word(op_code))
          begin
            // low byte now, high byte next cycle with the saved carry
            res_lo_d = cif.res;
            lo_carry_d = cif.cout;
            lo_zero_d = (cif.res == eal_pkg::BYTE_ZERO);
            hi_src_d = pair_high_val;
            word_sub_d = op_is_sub(op_code);
            busy_d = 1'b1;
            state_d = st_word_high;
          end
          else
          begin
            done_d = 1'b1;
            wr_byte_d = 1'b1;
            unique case (op_code)
              eal_pkg::op_and, eal_pkg::op_mask_with_imm:
                logic_res = dest_val & operand;
              eal_pkg::op_or, eal_pkg::op_merge_imm_bits:
                logic_res = dest_val | operand;
              eal_pkg::op_toggle_xor:
                logic_res = dest_val ^ operand;
              eal_pkg::op_raise_bits:
                logic_res = dest_val | imm_value;
              eal_pkg::op_drop_bits:
                logic_res = dest_val & (eal_pkg::ALL_ONES - imm_value);
              eal_pkg::op_self_mask_test:
                logic_res = dest_val & dest_val;
              default:
                logic_res = eal_pkg::BYTE_ZERO;
            endcase
            if (op_is_sub(op_code) || op_code == eal_pkg::op_add || op_code == eal_pkg::op_add_carry)
            begin
              res_lo_d = cif.res;
              flags_d[eal_pkg::FLAG_C] = cif.cout;
              flags_d[eal_pkg::FLAG_H] = cif.half;
              flags_d[eal_pkg::FLAG_N] = cif.res[7];
              flags_d[eal_pkg::FLAG_V] = cif.ovf;
              // a borrow chain only keeps zero while every byte was zero
              if (op_takes_carry(op_code) && cif.sub)
                flags_d[eal_pkg::FLAG_Z] = flags_q[eal_pkg::FLAG_Z] & (cif.res == eal_pkg::BYTE_ZERO);
              else
                flags_d[eal_pkg::FLAG_Z] = (cif.res == eal_pkg::BYTE_ZERO);
            end
            else
            begin
              res_lo_d = logic_res;
              flags_d[eal_pkg::FLAG_Z] = (logic_res == eal_pkg::BYTE_ZERO);
              flags_d[eal_pkg::FLAG_N] = logic_res[7];
              flags_d[eal_pkg::FLAG_V] = 1'b0;
            end
          end
        end
      end
      st_word_high:
      begin
        cif.a = hi_src_q;
        cif.b = eal_pkg::BYTE_ZERO;
        cif.cin = lo_carry_q;
        cif.sub = word_sub_q;
        res_hi_d = cif.res;
        flags_d[eal_pkg::FLAG_Z] = lo_zero_q & (cif.res == eal_pkg::BYTE_ZERO);
        flags_d[eal_pkg::FLAG_C] = cif.cout;
        flags_d[eal_pkg::FLAG_N] = cif.res[7];
        flags_d[eal_pkg::FLAG_V] = cif.ovf;
        flags_d[eal_pkg::FLAG_S] = cif.res[7] ^ cif.ovf;
        wr_pair_d = 1'b1;
        done_d = 1'b1;
        busy_d = 1'b0;
        state_d = st_idle;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= st_idle;
      flags_q <= eal_pkg::FLAGS_RESET;
      res_lo_q <= 8'h00;
      res_hi_q <= 8'h00;
      hi_src_q <= 8'h00;
      lo_carry_q <= 1'b0;
      lo_zero_q <= 1'b0;
      word_sub_q <= 1'b0;
      idx_q <= '0;
      idx_hi_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      wr_byte_q <= 1'b0;
      wr_pair_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      flags_q <= flags_d;
      res_lo_q <= res_lo_d;
      res_hi_q <= res_hi_d;
      hi_src_q <= hi_src_d;
      lo_carry_q <= lo_carry_d;
      lo_zero_q <= lo_zero_d;
      word_sub_q <= word_sub_d;
      idx_q <= idx_d;
      idx_hi_q <= idx_hi_d;
      busy_q <= busy_d;
      done_q <= done_d;
      wr_byte_q <= wr_byte_d;
      wr_pair_q <= wr_pair_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign busy = busy_q;
  assign done = done_q;
  assign wr_byte = wr_byte_q;
  assign wr_pair = wr_pair_q;
  assign wr_idx = idx_q;
  assign wr_idx_high = idx_hi_q;
  assign result_low = res_lo_q;
  assign result_high = res_hi_q;
  assign status_flags = flags_q;

endmodule : eal_alu_top

//--- bench/eal_alu_chk.sv
// timing and flag checks at the alu decoder port
`timescale 1ns/1ps
module eal_alu_chk #(
  parameter int unsigned IDX_W = 5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire eal_pkg::eal_op_t op_code,
  input wire logic busy,
  input wire logic done,
  input wire logic wr_byte,
  input wire logic wr_pair,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [IDX_W-1:0] wr_idx_high,
  input wire logic [7:0] result_low,
  input wire logic [7:0] result_high,
  input wire logic [7:0] status_flags
);
  wire logic wd = op_code inside {eal_pkg::op_word_pair_add_imm, eal_pkg::op_word_pair_minus_imm};
  wire logic tk = op_valid && !busy && (op_code != eal_pkg::op_nop);
  wire logic lg = tk && (op_code >= eal_pkg::op_and);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_byte; tk && !wd |=> done && wr_byte && !wr_pair; endproperty
  a_byte: assert property (p_byte) else $error("byte op latency");
  property p_word; tk && wd |=> busy && !done ##1 done && wr_pair && !busy; endproperty
  a_word: assert property (p_word) else $error("word op latency");
  property p_pair; wr_pair |-> wr_idx_high == wr_idx + 1'b1; endproperty
  a_pair: assert property (p_pair) else $error("pair index");
  property p_lgv; lg |=> !status_flags[3] && status_flags[1] == (result_low == 8'h00); endproperty
  a_lgv: assert property (p_lgv) else $error("logic flags");
  property p_lgc; lg |=> status_flags[0] == $past(status_flags[0]) && status_flags[5] == $past(status_flags[5]); endproperty
  a_lgc: assert property (p_lgc) else $error("logic touched carry");
  property p_bs; tk && !wd |=> $stable(status_flags[4]); endproperty
  a_bs: assert property (p_bs) else $error("byte op touched sign");
  property p_ws; wr_pair |-> status_flags[4] == (status_flags[2] ^ status_flags[3]); endproperty
  a_ws: assert property (p_ws) else $error("word sign flag");
  property p_n; done |-> status_flags[2] == (wr_pair ? result_high[7] : result_low[7]); endproperty
  a_n: assert property (p_n) else $error("negative flag");
endmodule : eal_alu_chk
bind eal_alu_top eal_alu_chk #(.IDX_W(IDX_W)) eal_alu_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n),
  .op_valid(op_valid), .op_code(op_code), .busy(busy), .done(done), .wr_byte(wr_byte), .wr_pair(wr_pair),
  .wr_idx(wr_idx), .wr_idx_high(wr_idx_high), .result_low(result_low), .result_high(result_high),
  .status_flags(status_flags));

//--- bench/eal_dec_model.sv
// register file standing in for the decoder side
`timescale 1ns/1ps
module eal_dec_model #(
  parameter int unsigned IDX_W = 5
) (
  input wire logic clk_sys,
  input wire logic [IDX_W-1:0] dest_idx,
  input wire logic wr_byte,
  input wire logic wr_pair,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [IDX_W-1:0] wr_idx_high,
  input wire logic [7:0] result_low,
  input wire logic [7:0] result_high,
  output logic [7:0] dest_val,
  output logic [7:0] pair_high_val
);
  logic [7:0] rf [2**IDX_W];
  assign dest_val = rf[dest_idx];
  assign pair_high_val = rf[dest_idx + 1'b1];
  always @(posedge clk_sys)
  begin
    if (wr_byte || wr_pair)
      rf[wr_idx] <= result_low;
    if (wr_pair)
      rf[wr_idx_high] <= result_high;
  end
endmodule : eal_dec_model

//--- bench/tb.sv
// self-checking bench for the arithmetic and logic unit
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t mismatch got %h want %h", $time, a, b); end end
module tb;
  localparam int unsigned IW = 5;
  logic clk_sys, busy, done, wr_byte, wr_pair;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  eal_pkg::eal_op_t op_code = eal_pkg::op_nop;
  logic [IW-1:0] dest_idx = 5'h00;
  logic [IW-1:0] wr_idx, wr_idx_high;
  logic [7:0] source_reg = 8'h00;
  logic [7:0] imm_value = 8'h00;
  logic [7:0] dest_val, pair_high_val, result_low, result_high, status_flags;
  logic [7:0] ef = 8'h00;
  int err_total = 0;
  int total_checks = 0;
  eal_alu_top #(.IDX_W(IW)) eal_alu_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid),
    .op_code(op_code), .dest_idx(dest_idx), .dest_val(dest_val), .source_reg(source_reg), .imm_value(imm_value),
    .pair_high_val(pair_high_val), .busy(busy), .done(done), .wr_byte(wr_byte), .wr_pair(wr_pair), .wr_idx(wr_idx),
    .wr_idx_high(wr_idx_high), .result_low(result_low), .result_high(result_high), .status_flags(status_flags));
  eal_dec_model #(.IDX_W(IW)) eal_dec_model_inst (.clk_sys(clk_sys), .dest_idx(dest_idx), .wr_byte(wr_byte),
    .wr_pair(wr_pair), .wr_idx(wr_idx), .wr_idx_high(wr_idx_high), .result_low(result_low),
    .result_high(result_high), .dest_val(dest_val), .pair_high_val(pair_high_val));
  // expected {high, low, flags}; carry-in is the previous expected carry
  function automatic logic [23:0] ref_f(input eal_pkg::eal_op_t o, input logic [7:0] d, s, k, h, f);
    logic [8:0] r;
    logic [16:0] w;
    logic [7:0] b, n;
    logic sb, bw, wm;
    n = f;
    wm = o == eal_pkg::op_word_pair_minus_imm;
    bw = o inside {eal_pkg::op_sub_borrow, eal_pkg::op_minus_imm_with_borrow};
    sb = bw || o inside {eal_pkg::op_sub, eal_pkg::op_minus_immediate};
    b = o inside {eal_pkg::op_minus_immediate, eal_pkg::op_minus_imm_with_borrow} ? k : s;
    r = {8'h00, f[0] && (bw || o == eal_pkg::op_add_carry)};
    r = sb ? {1'b0, d} - {1'b0, b} - r : {1'b0, d} + {1'b0, b} + r;
    w = wm ? {1'b0, h, d} - {9'h000, k} : {1'b0, h, d} + {9'h000, k};
    case (o)
      eal_pkg::op_word_pair_add_imm, eal_pkg::op_word_pair_minus_imm:
      begin
        n[2] = w[15];
        n[3] = wm ? h[7] && !w[15] : !h[7] && w[15];
        n[4] = n[2] ^ n[3];
        n[1] = w[15:0] == 16'h0000;
        n[0] = w[16];
        return {w[15:0], n};
      end
      eal_pkg::op_and: r = {1'b0, d & s};
      eal_pkg::op_mask_with_imm: r = {1'b0, d & k};
      eal_pkg::op_or: r = {1'b0, d | s};
      eal_pkg::op_merge_imm_bits, eal_pkg::op_raise_bits: r = {1'b0, d | k};
      eal_pkg::op_toggle_xor: r = {1'b0, d ^ s};
      eal_pkg::op_drop_bits: r = {1'b0, d & (8'hFF - k)};
      eal_pkg::op_self_mask_test: r = {1'b0, d};
      default:
      begin
        n[0] = r[8];
        n[3] = (r[7] != d[7]) && ((d[7] != b[7]) == sb);
        n[5] = d[4] ^ b[4] ^ r[4];
      end
    endcase
    n[1] = (r[7:0] == 8'h00) && (!bw || f[1]);
    n[2] = r[7];
    if (o >= eal_pkg::op_and)
      n[3] = 1'b0;
    return {8'h00, r[7:0], n};
  endfunction : ref_f
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // pk offers an add while a word op is busy, which must be refused
  task automatic run(input eal_pkg::eal_op_t o, input logic [IW-1:0] i, input logic [7:0] d, s, k, h, input logic pk);
    logic [23:0] e;
    logic w;
    int n;
    w = o inside {eal_pkg::op_word_pair_add_imm, eal_pkg::op_word_pair_minus_imm};
    e = ref_f(o, d, s, k, h, ef);
    n = 0;
    @(negedge clk_sys);
    eal_dec_model_inst.rf[i] = d;
    eal_dec_model_inst.rf[i + 1'b1] = h;
    op_code = o;
    dest_idx = i;
    source_reg = s;
    imm_value = k;
    op_valid = 1'b1;
    do
    begin
      @(negedge clk_sys);
      n++;
      op_valid = pk && n == 1;
      op_code = (pk && n == 1) ? eal_pkg::op_add : o;
    end
    while (done !== 1'b1 && n < 5);
    if (n >= 5)
    begin
      err_total++;
      end_sim();
    end
    `CHK(n, w ? eal_pkg::WORD_OP_CYCLES : eal_pkg::BYTE_OP_CYCLES)
    `CHK(result_low, e[15:8])
    `CHK(status_flags, e[7:0])
    if (w)
      `CHK(result_high, e[23:16])
    @(negedge clk_sys);
    `CHK(done, 1'b0)
    `CHK(eal_dec_model_inst.rf[i], e[15:8])
    if (w)
      `CHK(eal_dec_model_inst.rf[i + 1'b1], e[23:16])
    ef = e[7:0];
  endtask : run
  task automatic t_ops(input logic [7:0] d, s, k);
    for (int o = 1; o <= 16; o++)
      run(eal_pkg::eal_op_t'(o), 5'h03, d, s, k, 8'hA5, 1'b0);
    $display("t_ops done");
  endtask : t_ops
  task automatic t_word();
    run(eal_pkg::op_word_pair_add_imm, 5'h1F, 8'hFF, 8'h00, 8'h01, 8'hFF, 1'b1);
    run(eal_pkg::op_word_pair_minus_imm, 5'h18, 8'h00, 8'h00, 8'h01, 8'h80, 1'b1);
    run(eal_pkg::op_word_pair_add_imm, 5'h0A, 8'hFF, 8'h00, 8'h01, 8'h7F, 1'b1);
    // a strobed no-operation must neither complete nor touch the flags
    @(negedge clk_sys);
    op_code = eal_pkg::op_nop;
    op_valid = 1'b1;
    @(negedge clk_sys);
    op_valid = 1'b0;
    `CHK(done, 1'b0)
    `CHK(status_flags, ef)
    $display("t_word done");
  endtask : t_word
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    t_ops(8'hFF, 8'h01, 8'h01);
    t_ops(8'h80, 8'h01, 8'h7F);
    t_ops(8'h3C, 8'h3C, 8'hC3);
    t_word();
    end_sim();
  end
endmodule : tb
